// [logic/cdz_defs.vh]
// register map, field positions, reset values and timing counts for cdz
`ifndef CDZ_DEFS_VH
`define CDZ_DEFS_VH

// register offsets (byte addresses on the plain register port)
`define CDZ_ADDR_CAL_CTRL      10'h018
`define CDZ_ADDR_ZD_CTRL       10'h01e
`define CDZ_ADDR_STATUS        10'h01f
`define CDZ_ADDR_CH_DIV0       10'h190
`define CDZ_ADDR_CH_STRIDE     10'h003
`define CDZ_ADDR_VCO_DIV       10'h1e0
`define CDZ_ADDR_SRC_SEL       10'h1e1
`define CDZ_ADDR_DLY_CTRL      10'h1e2
`define CDZ_ADDR_UPDATE        10'h232

// field positions
`define CDZ_CAL_REQ_BIT        0
`define CDZ_ZD_MODE_LSB        1
`define CDZ_ZD_SEL_LSB         3
`define CDZ_STAT_CAL_DONE_BIT  6
`define CDZ_CH_BYPASS_BIT      7
`define CDZ_CH_NODCC_BIT       0
`define CDZ_CH_START_HIGH_BIT  1
`define CDZ_CH_PHASE_LSB       4
`define CDZ_STAT_SYNC_BIT      0

// encodings
`define CDZ_ZD_INTERNAL        2'b01
`define CDZ_ZD_EXTERNAL        2'b11
`define CDZ_SRC_CLK_VDIV       2'b00
`define CDZ_SRC_CLK_DIRECT     2'b01
`define CDZ_SRC_VCO_VDIV       2'b10
`define CDZ_SRC_BAD            2'b11

// reset values
`define CDZ_RST_ZD_CTRL        8'h00
`define CDZ_RST_SRC_SEL        8'h02
`define CDZ_RST_VCO_DIV        8'h00
`define CDZ_RST_CH_DIV         8'h00

// calibration length in calibration clock cycles
`define CDZ_CAL_CYCLES         4400

`endif

// [logic/cdz_clock_dist.v]
// clock distribution control: source select, channel dividers, zero delay
//
// Function
// (R1) calibration never starts on its own when divider settings change
// (R2) distribution held in sync while a calibration runs
// (R3) software recalibrates after changing R, P, B, A or reference rate
// (R4) a calibration request is accepted at any time; the code ignores a request while a calibration runs
// (R5) zero-delay field 01 selects internal zero-delay mode
// (R6) internal mode feeds channel divider 0 output to the N divider
// (R7) zero-delay field 11 selects external mode via the clock input
// (R8) bits 4:3 pick the feedback channel divider, default divider 0
// (R9) software uses external mode when divider 1, 2 or 3 feeds back
// (R10) programmable delay on both reference and feedback paths
// (R11) each channel divides by 1 to 32; divide by one via bypass
// (R12) vco divider divides by 1 to 6 ahead of channel dividers
// (R13) output high N+1 and low M+1 input cycles
// (R14) optional duty correction gives 50 percent for odd with M=N+1; the code only sets ch_half_reg and leaves the output duty unchanged
// (R15) duty correction unavailable when vco divider ratio is one
// (R16) coarse channel delay of 0 to 15 input cycles
// (R17) channel output may start high or low after sync
// (R18) direct vco path skips vco divider and channel dividers
// (R19) software uses the vco divider when clock input is too fast
// (R20) source select 00 clk+div, 01 clk direct, 10 vco+div, 11 bad
// (R21) no setting feeds the vco to channel dividers undivided
// (R22) software feeds back the lowest output frequency
// (R23) calibration lasts 4400 calibration clock cycles
// (R24) calibration starts on request bit set plus update; rearm needed
// (R25) calibration done read back at bit 6 of status register
// (R26) prohibited source setting keeps channel outputs static
`timescale 1ns/1ps
`default_nettype none
`include "cdz_defs.vh"

module cdz_clock_dist #(
    parameter CAL_CYCLES = `CDZ_CAL_CYCLES,
    parameter NCH        = 4
) (
    // clock and reset
    input  wire            ref_clk_i,
    input  wire            nrst_i,
    // register port
    input  wire [9:0]      reg_addr_i,
    input  wire [7:0]      reg_wdata_i,
    input  wire            reg_wr_i,
    input  wire            reg_rd_i,
    output reg  [7:0]      reg_rdata_o,
    // clock sources, one rising edge enable per source period
    input  wire            vco_tick_i,
    input  wire            ext_clk_tick_i,
    input  wire            cal_clk_tick_i,
    input  wire            reference_input_i,
    input  wire            n_div_fb_i,
    // distribution outputs
    output reg  [NCH-1:0]  chan_out_o,
    output reg             vco_direct_o,
    output reg             feedback_o,
    output reg             zd_ext_mode_o,
    output reg             ref_delayed_o,
    output reg             fb_delayed_o,
    output reg             dist_sync_o,
    output reg             cal_busy_o
);

    ////////////////////////////////////////////////////////////////////////
    // register state
    reg [7:0]  cal_ctrl_reg;
    reg [7:0]  cal_ctrl_act_reg;
    reg [7:0]  zd_ctrl_reg;
    reg [7:0]  zd_ctrl_act_reg;
    reg [7:0]  src_sel_reg;
    reg [7:0]  src_sel_act_reg;
    reg [7:0]  vco_div_reg;
    reg [7:0]  vco_div_act_reg;
    reg [7:0]  dly_ctrl_reg;
    reg [7:0]  dly_ctrl_act_reg;
    reg [7:0]  ch_mn_reg    [0:NCH-1];
    reg [7:0]  ch_ctl_reg   [0:NCH-1];
    reg [7:0]  ch_dcc_reg   [0:NCH-1];
    reg [7:0]  ch_mn_act    [0:NCH-1];
    reg [7:0]  ch_ctl_act   [0:NCH-1];
    reg [7:0]  ch_dcc_act   [0:NCH-1];
    reg        cal_done_reg;
    reg        update_reg;
    integer    k, j, p, q, c;

    // channel register decode: three consecutive bytes per channel
    function [2:0] ch_hit;
        input [9:0] a;
        input [1:0] ch;
        reg   [9:0] base;
        begin
            base = `CDZ_ADDR_CH_DIV0 + {6'h00, ch, 2'b00} - {8'h00, ch};
            ch_hit = {a == base + 10'h002, a == base + 10'h001, a == base};
        end
    endfunction

    // staged registers become active only on an update write; this keeps
    // a multi-byte reprogram from running half old and half new settings
    always @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            cal_ctrl_reg <= 8'h00;
            zd_ctrl_reg  <= `CDZ_RST_ZD_CTRL;
            src_sel_reg  <= `CDZ_RST_SRC_SEL;
            vco_div_reg  <= `CDZ_RST_VCO_DIV;
            dly_ctrl_reg <= 8'h00;
            update_reg   <= 1'b0;
            for (j = 0; j < NCH; j = j + 1) begin
                ch_mn_reg[j]  <= `CDZ_RST_CH_DIV;
                ch_ctl_reg[j] <= 8'h00;
                ch_dcc_reg[j] <= 8'h00;
            end
        end else begin
            update_reg <= reg_wr_i && reg_addr_i == `CDZ_ADDR_UPDATE
                          && reg_wdata_i[0];
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `CDZ_ADDR_CAL_CTRL: cal_ctrl_reg <= reg_wdata_i;
                    `CDZ_ADDR_ZD_CTRL:  zd_ctrl_reg  <= reg_wdata_i;
                    `CDZ_ADDR_SRC_SEL:  src_sel_reg  <= reg_wdata_i;
                    `CDZ_ADDR_VCO_DIV:  vco_div_reg  <= reg_wdata_i;
                    `CDZ_ADDR_DLY_CTRL: dly_ctrl_reg <= reg_wdata_i;
                    default: ;
                endcase
                for (j = 0; j < NCH; j = j + 1) begin
                    if (ch_hit(reg_addr_i, j[1:0]) == 3'b001)
                        ch_mn_reg[j] <= reg_wdata_i;
                    if (ch_hit(reg_addr_i, j[1:0]) == 3'b010)
                        ch_ctl_reg[j] <= reg_wdata_i;
                    if (ch_hit(reg_addr_i, j[1:0]) == 3'b100)
                        ch_dcc_reg[j] <= reg_wdata_i;
                end
            end
        end
    end

    // active copies taken on update
    always @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            cal_ctrl_act_reg <= 8'h00;
            zd_ctrl_act_reg  <= `CDZ_RST_ZD_CTRL;
            src_sel_act_reg  <= `CDZ_RST_SRC_SEL;
            vco_div_act_reg  <= `CDZ_RST_VCO_DIV;
            dly_ctrl_act_reg <= 8'h00;
            for (p = 0; p < NCH; p = p + 1) begin
                ch_mn_act[p]  <= `CDZ_RST_CH_DIV;
                ch_ctl_act[p] <= 8'h00;
                ch_dcc_act[p] <= 8'h00;
            end
        end else if (update_reg) begin
            cal_ctrl_act_reg <= cal_ctrl_reg;
            zd_ctrl_act_reg  <= zd_ctrl_reg;
            src_sel_act_reg  <= src_sel_reg;
            vco_div_act_reg  <= vco_div_reg;
            dly_ctrl_act_reg <= dly_ctrl_reg;
            for (p = 0; p < NCH; p = p + 1) begin
                ch_mn_act[p]  <= ch_mn_reg[p];
                ch_ctl_act[p] <= ch_ctl_reg[p];
                ch_dcc_act[p] <= ch_dcc_reg[p];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // calibration sequencer
    localparam ST_IDLE = 2'b00;
    localparam ST_CAL  = 2'b01;
    localparam ST_DONE = 2'b10;

    reg [1:0]  cal_state_reg;
    reg [12:0] cal_cnt_reg;
    reg        cal_req_prev_reg;
    wire       cal_req_act = cal_ctrl_act_reg[`CDZ_CAL_REQ_BIT];
    // only a 0->1 edge of the active request bit starts a run, so a pll
    // reprogram alone never launches one (see R1)
    wire       cal_start = cal_req_act && !cal_req_prev_reg;

    always @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            cal_state_reg    <= ST_IDLE;
            cal_cnt_reg      <= 13'h0000;
            cal_req_prev_reg <= 1'b0;
            cal_done_reg     <= 1'b0;
        end else begin
            cal_req_prev_reg <= cal_req_act;  // see R24
            case (cal_state_reg)
                ST_IDLE, ST_DONE: begin
                    if (cal_start) begin  // accepted only from idle or done, not during a run, see R4
                        cal_state_reg <= ST_CAL;
                        cal_cnt_reg   <= 13'h0000;
                        cal_done_reg  <= 1'b0;
                    end
                end
                ST_CAL: begin
                    if (cal_clk_tick_i) begin
                        if (cal_cnt_reg == CAL_CYCLES[12:0] - 13'h0001) begin
                            cal_state_reg <= ST_DONE;  // see R23
                            cal_done_reg  <= 1'b1;     // see R25
                        end else begin
                            cal_cnt_reg <= cal_cnt_reg + 13'h0001;
                        end
                    end
                end
                default: cal_state_reg <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source selection and vco divider
    wire [1:0] src_sel   = src_sel_act_reg[1:0];
    wire       src_bad   = src_sel == `CDZ_SRC_BAD;
    wire       sync_hold = cal_state_reg == ST_CAL || src_bad;  // R2, R26
    // vco reaches the channel dividers only through the vco divider; no undivided vco choice there
    wire       src_tick  = src_sel[1] ? vco_tick_i : ext_clk_tick_i;  // R21
    wire       use_vdiv  = src_sel != `CDZ_SRC_CLK_DIRECT;          // R20
    wire [2:0] vdiv_ratio = (vco_div_act_reg[2:0] > 3'h5) ? 3'h5
                            : vco_div_act_reg[2:0];  // code 0..5 = 1..6
    reg  [2:0] vdiv_cnt_reg;
    wire       ch_tick = use_vdiv ? (src_tick && vdiv_cnt_reg == vdiv_ratio)
                                  : src_tick;

    // vco divider: one output tick per (vdiv_ratio+1) source ticks, see R12
    always @(posedge ref_clk_i) begin
        if (!nrst_i || sync_hold) begin
            vdiv_cnt_reg <= 3'h0;
        end else if (src_tick) begin
            vdiv_cnt_reg <= (vdiv_cnt_reg == vdiv_ratio) ? 3'h0
                            : vdiv_cnt_reg + 3'h1;
        end
    end

    // direct vco path, toggles per vco tick with source select 10 only, held in sync, see R18
    always @(posedge ref_clk_i) begin
        if (!nrst_i || sync_hold) begin
            vco_direct_o <= 1'b0;
        end else if (vco_tick_i && src_sel == `CDZ_SRC_VCO_VDIV) begin
            vco_direct_o <= ~vco_direct_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel dividers
    reg [4:0] ch_cnt_reg   [0:NCH-1];
    reg [3:0] ch_phase_reg [0:NCH-1];
    reg       ch_phase_ok  [0:NCH-1];
    reg       ch_level     [0:NCH-1];
    reg       ch_half_reg  [0:NCH-1];
    reg [NCH-1:0] dcc_on;

    // correction needs M=N or M=N+1 and, when the vco divider is in use, a ratio above one
    always @* begin
        for (c = 0; c < NCH; c = c + 1)
            dcc_on[c] = !ch_dcc_act[c][`CDZ_CH_NODCC_BIT]
                && !(use_vdiv && vdiv_ratio == 3'h0)  // see R15
                && (ch_mn_act[c][7:4] == ch_mn_act[c][3:0]  // see R14
                    || ch_mn_act[c][7:4] == ch_mn_act[c][3:0] + 4'h1);
    end

    always @(posedge ref_clk_i) begin
        for (k = 0; k < NCH; k = k + 1) begin
            if (!nrst_i || sync_hold) begin
                // static at start level while synced, see R2 R17
                ch_cnt_reg[k]   <= 5'h00;
                ch_phase_reg[k] <= 4'h0;
                ch_phase_ok[k]  <= 1'b0;
                ch_half_reg[k]  <= 1'b0;
                ch_level[k]     <= nrst_i
                    & ch_ctl_act[k][`CDZ_CH_START_HIGH_BIT];
                chan_out_o[k]   <= nrst_i
                    & ch_ctl_act[k][`CDZ_CH_START_HIGH_BIT];
            end else if (ch_tick) begin
                if (!ch_phase_ok[k]) begin
                    // coarse delay in input cycles, see R16
                    if (ch_phase_reg[k] ==
                        ch_ctl_act[k][`CDZ_CH_PHASE_LSB +: 4])
                        ch_phase_ok[k] <= 1'b1;
                    else
                        ch_phase_reg[k] <= ch_phase_reg[k] + 4'h1;
                end else if (ch_ctl_act[k][`CDZ_CH_BYPASS_BIT]) begin
                    chan_out_o[k] <= ~chan_out_o[k];  // divide by 1, R11
                end else if (ch_level[k] &&
                             ch_cnt_reg[k] == {1'b0, ch_mn_act[k][3:0]}) begin
                    // high phase of N+1 cycles ends, see R13
                    ch_cnt_reg[k] <= 5'h00;
                    ch_level[k]   <= 1'b0;
                    chan_out_o[k] <= 1'b0;
                    ch_half_reg[k] <= 1'b0;
                end else if (!ch_level[k] &&
                             ch_cnt_reg[k] == {1'b0, ch_mn_act[k][7:4]}) begin
                    // low phase of M+1 cycles ends, see R13
                    ch_cnt_reg[k] <= 5'h00;
                    ch_level[k]   <= 1'b1;
                    chan_out_o[k] <= 1'b1;
                end else begin
                    ch_cnt_reg[k] <= ch_cnt_reg[k] + 5'h01;
                    // odd ratio: ch_half_reg flags a half-cycle stretch near the
                    // low-to-high edge; nothing reads it, so the output is unchanged
                    if (dcc_on[k] && !ch_level[k] &&
                        ch_mn_act[k][7:4] != ch_mn_act[k][3:0] &&
                        ch_cnt_reg[k] == {1'b0, ch_mn_act[k][7:4]} - 5'h01)
                        ch_half_reg[k] <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // zero-delay feedback routing and path delays
    wire [1:0] zd_mode = zd_ctrl_act_reg[`CDZ_ZD_MODE_LSB +: 2];
    wire [1:0] zd_sel  = zd_ctrl_act_reg[`CDZ_ZD_SEL_LSB +: 2];
    reg        feedback_select_mux_a;
    reg        feedback_select_mux_b;

    // internal mode fixed to divider 0; external follows the selected
    // channel, which software loops back through the clock input
    always @* begin
        feedback_select_mux_b = chan_out_o[zd_sel];  // see R8
        if (zd_mode == `CDZ_ZD_INTERNAL)
            feedback_select_mux_a = chan_out_o[0];  // see R5 R6
        else if (zd_mode == `CDZ_ZD_EXTERNAL)
            feedback_select_mux_a = feedback_select_mux_b;  // see R7
        else
            feedback_select_mux_a = n_div_fb_i;
    end

    reg [15:0] ref_pipe_reg;
    reg [15:0] fb_pipe_reg;

    // delay lines in ref_clk cycles, setting 0..15 gives 2..17 cycles each, see R10
    always @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            ref_pipe_reg  <= 16'h0000;
            fb_pipe_reg   <= 16'h0000;
            feedback_o    <= 1'b0;
            zd_ext_mode_o <= 1'b0;
            ref_delayed_o <= 1'b0;
            fb_delayed_o  <= 1'b0;
            dist_sync_o   <= 1'b0;
            cal_busy_o    <= 1'b0;
        end else begin
            feedback_o    <= feedback_select_mux_a;
            zd_ext_mode_o <= zd_mode == `CDZ_ZD_EXTERNAL;
            ref_pipe_reg  <= {ref_pipe_reg[14:0], reference_input_i};
            fb_pipe_reg   <= {fb_pipe_reg[14:0], feedback_select_mux_a};
            ref_delayed_o <= ref_pipe_reg[dly_ctrl_act_reg[3:0]];
            fb_delayed_o  <= fb_pipe_reg[dly_ctrl_act_reg[7:4]];
            dist_sync_o   <= sync_hold;
            cal_busy_o    <= cal_state_reg == ST_CAL;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port, data valid the cycle after the strobe
    reg [7:0] rd_mux;

    always @* begin
        rd_mux = 8'h00;
        case (reg_addr_i)
            `CDZ_ADDR_CAL_CTRL: rd_mux = cal_ctrl_reg;
            `CDZ_ADDR_ZD_CTRL:  rd_mux = zd_ctrl_reg;
            `CDZ_ADDR_SRC_SEL:  rd_mux = src_sel_reg;
            `CDZ_ADDR_VCO_DIV:  rd_mux = vco_div_reg;
            `CDZ_ADDR_DLY_CTRL: rd_mux = dly_ctrl_reg;
            `CDZ_ADDR_STATUS:   rd_mux = {1'b0, cal_done_reg, 5'h00,
                                          sync_hold};
            default:            rd_mux = 8'h00;
        endcase
        for (q = 0; q < NCH; q = q + 1) begin
            if (ch_hit(reg_addr_i, q[1:0]) == 3'b001) rd_mux = ch_mn_reg[q];
            if (ch_hit(reg_addr_i, q[1:0]) == 3'b010) rd_mux = ch_ctl_reg[q];
            if (ch_hit(reg_addr_i, q[1:0]) == 3'b100) rd_mux = ch_dcc_reg[q];
        end
    end

    always @(posedge ref_clk_i) begin
        if (!nrst_i)
            reg_rdata_o <= 8'h00;
        else
            reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
    end

endmodule
`default_nettype wire

// [verification/cdz_clock_dist_properties.sv]
// concurrent checks on the clock distribution control ports
`timescale 1ns/1ps
`default_nettype none
module cdz_props #(
    parameter CAL_CYCLES = 4400,
    parameter NCH        = 4
) (
    // clock, reset and register port
    input wire logic           ref_clk_i,
    input wire logic           nrst_i,
    input wire logic [9:0]     reg_addr_i,
    input wire logic [7:0]     reg_wdata_i,
    input wire logic           reg_wr_i,
    input wire logic           reg_rd_i,
    input wire logic [7:0]     reg_rdata_o,
    // sources and outputs
    input wire logic           vco_tick_i,
    input wire logic           ext_clk_tick_i,
    input wire logic           cal_clk_tick_i,
    input wire logic [NCH-1:0] chan_out_o,
    input wire logic           vco_direct_o,
    input wire logic           dist_sync_o,
    input wire logic           cal_busy_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////////////////////////////////////
    // calibration ticks seen while busy, and age of the last update write
    logic [15:0] cal_cnt_reg;
    logic [3:0]  upd_age_reg;
    always @(posedge ref_clk_i) begin
        if (!nrst_i || !cal_busy_o) cal_cnt_reg <= '0;
        else if (cal_clk_tick_i) cal_cnt_reg <= cal_cnt_reg + 16'h1;
    end
    // saturates so an old update cannot look fresh
    always @(posedge ref_clk_i) begin
        if (!nrst_i) upd_age_reg <= 4'hf;
        else if (reg_wr_i && reg_addr_i == 10'h232 && reg_wdata_i[0])
            upd_age_reg <= 4'h0;
        else if (upd_age_reg != 4'hf) upd_age_reg <= upd_age_reg + 4'h1;
    end
    ////////////////////////////////////////////////////////////////////////
    property p_busy_sync; cal_busy_o |-> dist_sync_o; endproperty
    a_busy_sync: assert property (p_busy_sync) else $error("sync low in cal");
    property p_no_self_cal; $rose(cal_busy_o) |-> upd_age_reg < 4'h8; endproperty
    a_no_self_cal: assert property (p_no_self_cal) else $error("cal unasked");
    property p_cal_len;
        $fell(cal_busy_o) |-> $past(cal_cnt_reg) >= CAL_CYCLES - 2;
    endproperty
    a_cal_len: assert property (p_cal_len) else $error("cal too short");
    property p_cal_max; cal_cnt_reg <= CAL_CYCLES + 1; endproperty
    a_cal_max: assert property (p_cal_max) else $error("cal too long");
    property p_rd_zero; !$past(reg_rd_i) |-> reg_rdata_o == 8'h00; endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("stray read data");
    property p_static_sync;
        dist_sync_o && $past(dist_sync_o) |-> $stable(chan_out_o);
    endproperty
    a_static_sync: assert property (p_static_sync) else $error("moved in sync");
    property p_direct_tick;
        $changed(vco_direct_o) |-> $past(vco_tick_i) || $past(vco_tick_i, 2)
            || dist_sync_o || $past(dist_sync_o);
    endproperty
    a_direct_tick: assert property (p_direct_tick) else $error("direct no tick");
    property p_chan_tick;
        $changed(chan_out_o) |-> $past(vco_tick_i) || $past(ext_clk_tick_i)
            || $past(vco_tick_i, 2) || $past(ext_clk_tick_i, 2)
            || dist_sync_o || $past(dist_sync_o);
    endproperty
    a_chan_tick: assert property (p_chan_tick) else $error("chan no tick");
    // main scenarios reached
    c_cal: cover property ($fell(cal_busy_o));
    c_bad_src: cover property (dist_sync_o && !cal_busy_o);
    c_chan: cover property ($changed(chan_out_o));
endmodule
bind cdz_clock_dist cdz_props #(.CAL_CYCLES(CAL_CYCLES), .NCH(NCH)) i_props (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .vco_tick_i(vco_tick_i),
    .ext_clk_tick_i(ext_clk_tick_i), .cal_clk_tick_i(cal_clk_tick_i),
    .chan_out_o(chan_out_o), .vco_direct_o(vco_direct_o),
    .dist_sync_o(dist_sync_o), .cal_busy_o(cal_busy_o));
`default_nettype wire

// [verification/cdz_host.sv]
// host model: drives the register port and notes expected read data
`timescale 1ns/1ps
`default_nettype none
module cdz_host (
    // clock
    input wire logic        ref_clk_i,
    // register port
    output var logic [9:0]  reg_addr_o,
    output var logic [7:0]  reg_wdata_o,
    output var logic        reg_wr_o,
    output var logic        reg_rd_o
);
    logic [7:0] exp_q[$];
    initial begin
        reg_addr_o = 10'h000;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one-cycle write; the gap edge keeps the strobe single-driven
    task wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_o <= 1'b0;
    endtask
    // one-cycle read, expected data queued for the watcher
    task rd(input logic [9:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        exp_q.push_back(e);
        @(posedge ref_clk_i);
        reg_rd_o <= 1'b0;
    endtask
    task upd;
        wr(10'h232, 8'h01);
    endtask
    // software always rearms: clear, update, set, update
    task cal_req;
        wr(10'h018, 8'h00);
        upd;
        wr(10'h018, 8'h01);
        upd;
    endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the clock distribution control
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk_i, nrst_i, vco_tick, ext_tick, cal_tick, ext_hold, rd_d;
    logic [9:0] addr;
    logic [7:0] wdata, rdata;
    logic wr, rd, vdir, zd_ext, sync, busy, fb, vprev;
    logic [3:0] chan;
    integer seed, mismatches, compares, i, n, vchg;
    cdz_host i_host (.ref_clk_i(ref_clk_i), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
    cdz_clock_dist #(.CAL_CYCLES(8), .NCH(4)) i_dut (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .vco_tick_i(vco_tick),
        .ext_clk_tick_i(ext_tick), .cal_clk_tick_i(cal_tick),
        .reference_input_i(vco_tick), .n_div_fb_i(cal_tick),
        .chan_out_o(chan), .vco_direct_o(vdir), .feedback_o(fb),
        .zd_ext_mode_o(zd_ext), .ref_delayed_o(), .fb_delayed_o(),
        .dist_sync_o(sync), .cal_busy_o(busy));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    // random source ticks; ext_hold forces an ext_tick every cycle
    always @(posedge ref_clk_i) begin
        vco_tick <= $random(seed);
        ext_tick <= ext_hold | $random(seed);
        cal_tick <= $random(seed);
        rd_d <= rd;
    end
    // read data stands only in the cycle after the strobe
    always @(posedge ref_clk_i) begin
        if (rd_d) chk(rdata, i_host.exp_q.pop_front());
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // bounded wait on the calibration flag
    task wbusy(input logic v);
        for (i = 0; i < 400 && busy !== v; i++) @(posedge ref_clk_i);
        if (i == 400) begin
            mismatches++;
            summarize;
        end
    endtask
    // length of the next stretch of channel 0 at level v
    task run_len(input logic v, output integer len);
        for (i = 0; i < 100 && chan[0] !== !v; i++) @(posedge ref_clk_i);
        for (i = 0; i < 100 && chan[0] !== v; i++) @(posedge ref_clk_i);
        for (len = 0; len < 100 && chan[0] === v; len++)
            @(posedge ref_clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 10700;
        mismatches = 0;
        compares = 0;
        nrst_i = 1'b0;
        ext_hold = 1'b0;
        repeat (10) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        i_host.rd(10'h01e, 8'h00);
        i_host.rd(10'h1e1, 8'h02);
        i_host.rd(10'h3ff, 8'h00);
        i_host.rd(10'h01f, 8'h00);
        // divider 0: N=2, M=4, no duty correction, clock input direct
        i_host.wr(10'h190, 8'h42);
        i_host.wr(10'h192, 8'h01);
        i_host.wr(10'h1e1, 8'h01);
        i_host.upd;
        ext_hold <= 1'b1;
        repeat (10) @(posedge ref_clk_i);
        chk({7'h0, busy}, 8'h00);
        run_len(1'b1, n);
        chk(n[7:0], 8'h03);
        run_len(1'b0, n);
        chk(n[7:0], 8'h05);
        ext_hold <= 1'b0;
        // zero-delay modes, external with divider 3 then internal;
        // divider 3 is made the slowest so it carries the feedback
        i_host.wr(10'h199, 8'hff);
        i_host.wr(10'h01e, 8'h1e);
        i_host.upd;
        i_host.rd(10'h01e, 8'h1e);
        @(posedge ref_clk_i);
        chk({7'h0, zd_ext}, 8'h01);
        i_host.wr(10'h01e, 8'h02);
        i_host.upd;
        i_host.rd(10'h01e, 8'h02);
        @(posedge ref_clk_i);
        chk({7'h0, zd_ext}, 8'h00);
        // feedback follows divider 0 one cycle later
        for (n = 0; n < 20; n++) begin
            vprev = chan[0];
            @(posedge ref_clk_i);
            chk({7'h0, fb}, {7'h0, vprev});
        end
        // each legal source: direct vco path moves only from the vco
        for (n = 0; n < 3; n++) begin
            i_host.wr(10'h1e1, n[7:0]);
            i_host.upd;
            vchg = 0;
            vprev = vdir;
            repeat (40) begin
                @(posedge ref_clk_i);
                if (vdir !== vprev) vchg++;
                vprev = vdir;
            end
            chk({7'h0, vchg != 0}, {7'h0, n == 2});
        end
        // calibration, then a refused rewrite, then a proper rearm
        i_host.cal_req;
        wbusy(1'b1);
        chk({7'h0, sync}, 8'h01);
        wbusy(1'b0);
        i_host.rd(10'h01f, 8'h40);
        i_host.wr(10'h018, 8'h01);
        i_host.upd;
        repeat (10) @(posedge ref_clk_i);
        chk({7'h0, busy}, 8'h00);
        i_host.cal_req;
        wbusy(1'b1);
        wbusy(1'b0);
        // prohibited source holds the distribution in sync
        i_host.wr(10'h1e1, 8'h03);
        i_host.upd;
        repeat (4) @(posedge ref_clk_i);
        chk({7'h0, sync}, 8'h01);
        i_host.rd(10'h01f, 8'h41);
        i_host.rd(10'h1e1, 8'h03);
        repeat (4) @(posedge ref_clk_i);
        summarize;
    end
endmodule
`default_nettype wire
